// *** verilog/pss_serial_port.sv ***
// three-wire serial port of the pressure sensor
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.svh"
module pss_serial_port #(
    parameter logic [10:0] CONV_TICKS      = 11'(`PSS_CONV_TICKS),
    parameter logic [15:0] CALIB_WORD_ONE   = `PSS_CALIB_ONE,
    parameter logic [15:0] CALIB_WORD_TWO   = `PSS_CALIB_TWO,
    parameter logic [15:0] CALIB_WORD_THREE = `PSS_CALIB_THREE,
    parameter logic [15:0] CALIB_WORD_FOUR  = `PSS_CALIB_FOUR
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        sclk,
    input  wire logic        din,
    input  wire logic        conv_clk,
    input  wire logic [15:0] adc_sample,
    output logic             dout,
    output logic             adc_start,
    output logic             adc_temp
);
    import pss_pkg::*;

    logic          sclk_s1;
    logic          sclk_s2;
    logic          sclk_s3;
    logic          din_s1;
    logic          din_s2;
    logic          cclk_s1;
    logic          cclk_s2;
    logic          cclk_s3;
    logic [19:0]   hist;
    pss_state_type state;
    logic [5:0]    cnt;
    logic [3:0]    code;
    logic [10:0]   conv_cnt;
    logic [31:0]   shreg;
    logic          sclk_rise;
    logic          cclk_rise;
    logic          reset_hit;
    logic          is_conv;
    logic          is_calib;
    logic          stop_end;
    logic          conv_done;
    logic          conv_end;
    logic          res_end;
    logic          cal_end;
    logic [15:0]   clamped;

    // two-stage synchronisers, third stage for edge detection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            din_s1  <= 1'b0;
            din_s2  <= 1'b0;
            cclk_s1 <= 1'b0;
            cclk_s2 <= 1'b0;
            cclk_s3 <= 1'b0;
        end else begin
            sclk_s1 <= sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            din_s1  <= din;
            din_s2  <= din_s1;
            cclk_s1 <= conv_clk;
            cclk_s2 <= cclk_s1;
            cclk_s3 <= cclk_s2;
        end
    end

    // edge strobes and frame decode
    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign cclk_rise = cclk_s2 & ~cclk_s3;
    assign reset_hit = sclk_rise &&
        ({hist, din_s2} == `PSS_RESET_PATTERN);
    assign is_conv  = (code == `PSS_CODE_PRESS) ||
                      (code == `PSS_CODE_TEMP);
    assign is_calib = (code == `PSS_CODE_W13) ||
                      (code == `PSS_CODE_W24);
    assign stop_end = sclk_rise && (state == PSS_STOP) &&
                      !din_s2 && (cnt == `PSS_STOP_LAST);
    assign conv_done = (conv_cnt == CONV_TICKS);
    assign conv_end  = (state == PSS_CONV) && conv_done;
    assign res_end  = sclk_rise && (state == PSS_RESULT) &&
                      (cnt == `PSS_RESULT_BITS);
    assign cal_end  = sclk_rise && (state == PSS_CALIB) &&
                      (cnt == `PSS_CALIB_BITS);

    // result limited to the converter's output span
    assign clamped = (adc_sample < `PSS_RESULT_MIN) ? `PSS_RESULT_MIN :
                     (adc_sample > `PSS_RESULT_MAX) ? `PSS_RESULT_MAX :
                     adc_sample;

    // history of din bits taken on rising sclk
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hist <= 20'h00000;
        end else if (sclk_rise) begin
            hist <= {hist[18:0], din_s2};
        end
    end

    // protocol sequencer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PSS_IDLE;
            cnt   <= 6'h00;
            code  <= 4'h0;
        end else if (reset_hit) begin
            state <= PSS_IDLE;
            cnt   <= 6'h00;
        end else begin
            unique case (state)
                PSS_IDLE: begin
                    if (sclk_rise) begin
                        if (!din_s2) begin
                            cnt <= 6'h00;
                        end else if (cnt == `PSS_START_LAST) begin
                            state <= PSS_SETUP;
                            cnt   <= 6'h00;
                        end else begin
                            cnt <= cnt + 6'h01;
                        end
                    end
                end
                PSS_SETUP: begin
                    if (sclk_rise) begin
                        code <= {code[2:0], din_s2};
                        if (cnt == `PSS_SETUP_LAST) begin
                            state <= PSS_STOP;
                            cnt   <= 6'h00;
                        end else begin
                            cnt <= cnt + 6'h01;
                        end
                    end
                end
                PSS_STOP: begin
                    if (sclk_rise) begin
                        cnt <= 6'h00;
                        if (din_s2) begin
                            state <= PSS_IDLE; // broken stop
                        end else if (cnt != `PSS_STOP_LAST) begin
                            cnt <= cnt + 6'h01;
                        end else if (is_conv) begin
                            state <= PSS_ACK;
                        end else if (is_calib) begin
                            state <= PSS_CALIB;
                        end else begin
                            state <= PSS_IDLE;
                        end
                    end
                end
                PSS_ACK: begin
                    if (sclk_rise) begin
                        if (cnt == `PSS_ACK_LAST) begin
                            state <= PSS_CONV;
                            cnt   <= 6'h00;
                        end else begin
                            cnt <= cnt + 6'h01;
                        end
                    end
                end
                PSS_CONV: begin
                    if (conv_done) begin
                        state <= PSS_RESULT;
                        cnt   <= 6'h00;
                    end
                end
                PSS_RESULT: begin
                    if (res_end) begin
                        state <= PSS_IDLE;
                        cnt   <= 6'h00;
                    end else if (sclk_rise) begin
                        cnt <= cnt + 6'h01;
                    end
                end
                PSS_CALIB: begin
                    if (cal_end) begin
                        state <= PSS_IDLE;
                        cnt   <= 6'h00;
                    end else if (sclk_rise) begin
                        cnt <= cnt + 6'h01;
                    end
                end
                default: begin
                    state <= PSS_IDLE;
                    cnt   <= 6'h00;
                end
            endcase
        end
    end

    // conversion timing on the slow conversion clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt  <= 11'h000;
            adc_start <= 1'b0;
            adc_temp  <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            if (stop_end && is_conv && !reset_hit) begin
                conv_cnt  <= 11'h000;
                adc_start <= 1'b1;
                adc_temp  <= (code == `PSS_CODE_TEMP);
            end else if ((state == PSS_ACK || state == PSS_CONV) &&
                         cclk_rise && !conv_done) begin
                conv_cnt <= conv_cnt + 11'h001;
            end
        end
    end

    // output shifter and status on dout
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dout  <= 1'b0;
            shreg <= 32'h00000000;
        end else if (reset_hit) begin
            dout <= 1'b0;
        end else if (stop_end && is_conv) begin
            dout <= 1'b1;
        end else if (stop_end && is_calib) begin
            if (code == `PSS_CODE_W13) begin
                shreg <= {CALIB_WORD_ONE, CALIB_WORD_THREE};
            end else begin
                shreg <= {CALIB_WORD_TWO, CALIB_WORD_FOUR};
            end
        end else if (conv_end) begin
            dout  <= 1'b0;
            shreg <= {clamped, 16'h0000};
        end else if (res_end || cal_end) begin
            dout <= 1'b0;
        end else if (sclk_rise &&
                     (state == PSS_RESULT || state == PSS_CALIB)) begin
            dout  <= shreg[31];
            shreg <= {shreg[30:0], 1'b0};
        end
    end

    default clocking pss_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    ack_raise_a:
    assert property (stop_end && is_conv && !reset_hit
                     |=> dout && adc_start)
        else $error("no acknowledge on last stop bit");

    conv_busy_a:
    assert property (state == PSS_CONV |-> dout)
        else $error("dout low while converting");

    done_fall_a:
    assert property (conv_end && !reset_hit
                     |=> !dout && state == PSS_RESULT)
        else $error("end of conversion not signalled");

    reset_idle_a:
    assert property (reset_hit |=> state == PSS_IDLE && !dout)
        else $error("reset pattern not honoured");

    result_len_a:
    assert property (state == PSS_RESULT && sclk_rise &&
                     cnt == 6'h0f && !reset_hit
                     |=> state == PSS_RESULT ##0 cnt == 6'h10)
        else $error("result readout length wrong");

    pause_hold_a:
    assert property (state == PSS_RESULT && !sclk_rise &&
                     !reset_hit |=> $stable(cnt) && $stable(dout))
        else $error("readout moved without sclk");

    launch_edge_a:
    assert property ($changed(dout) |->
                     $past(sclk_rise) || $past(conv_end))
        else $error("dout changed off a rising sclk");

    range_a:
    assert property (conv_end && !reset_hit
                     |=> shreg[31:16] >= `PSS_RESULT_MIN &&
                     shreg[31:16] <= `PSS_RESULT_MAX)
        else $error("result out of range");

    calib_load_a:
    assert property (stop_end && code == `PSS_CODE_W13 && !reset_hit
                     |=> shreg == {CALIB_WORD_ONE, CALIB_WORD_THREE})
        else $error("wrong calibration words loaded");

    start_seen_a:
    assert property (state == PSS_IDLE && sclk_rise && din_s2 &&
                     cnt == `PSS_START_LAST && !reset_hit
                     |=> state == PSS_SETUP)
        else $error("start pattern missed");

    idle_return_a:
    assert property ((res_end || cal_end) && !reset_hit
                     |=> state == PSS_IDLE && !dout)
        else $error("port did not return to idle");

    start_pulse_a:
    assert property (adc_start |=> !adc_start)
        else $error("conversion start not a pulse");

endmodule
`default_nettype wire

// *** verilog/pss_consts.svh ***
// constants for the sensor serial port
// Summary of operation
// - capture din and launch dout on rising sclk edges
// - frame is three high start bits, four setup bits, three low stops
// - setup picks pressure, temperature, words one/three or two/four
// - dout carries result or calibration data and conversion status
// - on conversions dout rises during the last stop bit
// - dout falling from high marks end of conversion
// - seventeen further clocks shift out the sixteen bit result
// - stopped sclk pauses readout; position is kept
// - the 21-bit reset pattern returns the port to idle anywhere
// - dout may toggle during reset; host ignores it
// - results are 16-bit values from 5000 to 37000
// - four 16-bit calibration words, 64 bits in all
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
`define PSS_START_LAST   6'h02
`define PSS_SETUP_LAST   6'h03
`define PSS_STOP_LAST    6'h02
`define PSS_ACK_LAST     6'h01
`define PSS_RESULT_BITS  6'h10
`define PSS_CALIB_BITS   6'h20
`define PSS_CODE_PRESS   4'ha
`define PSS_CODE_TEMP    4'h9
`define PSS_CODE_W13     4'h5
`define PSS_CODE_W24     4'h6
`define PSS_RESET_PATTERN 21'h155540
`define PSS_RESULT_MIN   16'h1388
`define PSS_RESULT_MAX   16'h9088
`define PSS_CONV_TIME_MS 35
`define PSS_CONV_CLK_HZ  32768
`define PSS_CONV_TICKS (`PSS_CONV_TIME_MS * `PSS_CONV_CLK_HZ / 1000)
`define PSS_CALIB_ONE    16'h1234
`define PSS_CALIB_TWO    16'h5678
`define PSS_CALIB_THREE  16'h9abc
`define PSS_CALIB_FOUR   16'hdef0
`endif

// *** verilog/pss_pkg.sv ***
// types of the sensor serial port
package pss_pkg;
    typedef enum logic [2:0] {
        PSS_IDLE   = 3'h0,
        PSS_SETUP  = 3'h1,
        PSS_STOP   = 3'h3,
        PSS_ACK    = 3'h2,
        PSS_CONV   = 3'h6,
        PSS_RESULT = 3'h7,
        PSS_CALIB  = 3'h5
    } pss_state_type;
endpackage

// *** sim/pss_host_model.sv ***
// host side model: drives sclk and din, samples dout
`timescale 1ns/1ns
`default_nettype none
module pss_host_model (
    input  wire logic mclk,
    input  wire logic dout,
    output var logic  sclk,
    output var logic  din
);
    // sclk stands still low outside frames
    initial begin
        sclk = 1'b0;
        din  = 1'b0;
    end

    // wait some mclk edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // shift n bits msb first; 160 ns sclk period, dout read at the fall
    task automatic shift(input logic [31:0] v, input int n,
                         output logic [31:0] q);
        q = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            din = v[i];            // changed with the falling sclk
            tick(4);
            sclk = 1'b1;           // device captures here
            tick(4);
            sclk = 1'b0;           // host makes the clock
            q = {q[30:0], dout};   // read on the falling edge
        end
    endtask

    // resync pattern; dout during it is not looked at
    task automatic send_reset();
        logic [31:0] q;
        shift(32'h155540, 21, q);
    endtask

    // hold sclk low until dout falls, bounded
    task automatic wait_fall(input int limit, output logic ok);
        int n;
        n = 0;
        while (dout !== 1'b0 && n < limit) begin
            tick(1);
            n++;
        end
        ok = (dout === 1'b0);
    endtask
endmodule
`default_nettype wire

// *** sim/tb_pss_serial_port.sv ***
// self-checking bench of the sensor serial port
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.svh"
module tb_pss_serial_port;
    import pss_pkg::*;
    logic        mclk;
    logic        rst_n;
    logic        conv_clk;
    logic [15:0] adc_sample;
    wire logic   sclk;
    wire logic   din;
    wire logic   dout;
    wire logic   adc_start;
    wire logic   adc_temp;
    int          error_cnt;
    int          num_checks;
    int          start_cnt;
    int          cyc;

    pss_serial_port #(.CONV_TICKS(11'h004)) i_dut (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .sclk       (sclk),
        .din        (din),
        .conv_clk   (conv_clk),
        .adc_sample (adc_sample),
        .dout       (dout),
        .adc_start  (adc_start),
        .adc_temp   (adc_temp)
    );

    pss_host_model i_host (
        .mclk (mclk),
        .dout (dout),
        .sclk (sclk),
        .din  (din)
    );

    // 50 mhz system clock and free running conversion clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        conv_clk = 1'b0;
        forever #15259 conv_clk = ~conv_clk;
    end

    // count start pulses and cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (adc_start === 1'b1)
            start_cnt++;
        if (cyc == 60000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // calibration frame: 32 bits of two words, then idle
    task automatic run_calib(input logic [3:0] code, input logic [31:0] exp);
        logic [31:0] q;
        logic [31:0] r;
        i_host.shift({22'h0, 3'h7, code, 3'h0}, 10, q);
        check(q[0], 1'b0);
        i_host.shift(32'h0, 32, q);
        i_host.shift(32'h0, 1, r);
        check(q, exp);
        check(r[0], 1'b0);
        $display("calib code %h done", code);
    endtask

    // conversion with ack, wait, paused readout
    task automatic run_conv(input logic [3:0] code, input logic [15:0] adc,
                            input logic [15:0] exp, input logic temp);
        logic [31:0] q;
        logic [31:0] r;
        logic        ok;
        int          s;
        int          c;
        adc_sample = adc;
        i_host.send_reset();
        s = start_cnt;
        i_host.shift({22'h0, 3'h7, code, 3'h0}, 10, q);
        check(q[1:0], 2'b01);
        check(32'(start_cnt - s), 32'h1);
        check(adc_temp, temp);
        i_host.shift(32'h0, 2, q);
        check(q[1:0], 2'b11);
        c = cyc;
        i_host.wait_fall(9000, ok);
        check(ok, 1'b1);
        // conversion lasts more than two conversion clock periods
        check((cyc - c) > 4000, 1'b1);
        i_host.shift(32'h0, 8, q);
        i_host.tick(40);                      // readout held
        i_host.shift(32'h0, 9, r);            // last eight result bits, then the low end bit
        check({q[7:0], r[8:1]}, exp);
        check(r[0], 1'b0);
        $display("conversion code %h done", code);
    endtask

    // resync from mid readout, then a refused setup code
    task automatic run_abort();
        logic [31:0] q;
        logic [31:0] r;
        int          s;
        i_host.shift({22'h0, 3'h7, `PSS_CODE_W13, 3'h0}, 10, q);
        i_host.shift(32'h0, 5, q);            // readout left part done
        i_host.send_reset();
        run_calib(`PSS_CODE_W24, {`PSS_CALIB_TWO, `PSS_CALIB_FOUR});
        s = start_cnt;
        i_host.shift({22'h0, 3'h7, 4'h0, 3'h0}, 10, q);
        i_host.shift(32'h0, 6, r);
        check(q, 32'h0);
        check(r, 32'h0);
        check(32'(start_cnt - s), 32'h0);
        $display("abort test done");
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        adc_sample = 16'h0;
        error_cnt = 0;
        num_checks = 0;
        start_cnt = 0;
        cyc = 0;
        i_host.tick(10);
        rst_n = 1'b1;
        i_host.tick(3);
        check(dout, 1'b0);
        run_calib(`PSS_CODE_W13, {`PSS_CALIB_ONE, `PSS_CALIB_THREE});
        run_calib(`PSS_CODE_W24, {`PSS_CALIB_TWO, `PSS_CALIB_FOUR});
        run_conv(`PSS_CODE_PRESS, 16'h4321, 16'h4321, 1'b0);
        run_conv(`PSS_CODE_TEMP, 16'h0010, `PSS_RESULT_MIN, 1'b1);
        run_conv(`PSS_CODE_PRESS, 16'hffff, `PSS_RESULT_MAX, 1'b0);
        run_abort();
        print_verdict();
    end
endmodule
`default_nettype wire
